// File: rtl/dtc_consts.vh
// Constants for the tone transceiver control block.
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH
`define DTC_CLK_KHZ 125000
`define DTC_BURST_MS 51
`define DTC_LONG_MS 102
`define DTC_BURST_CYCLES (`DTC_BURST_MS * `DTC_CLK_KHZ)
`define DTC_LONG_CYCLES (`DTC_LONG_MS * `DTC_CLK_KHZ)
`define DTC_CNT_W 24
`define DTC_CRA_TONE_EN 0
`define DTC_CRA_PROGRESS 1
`define DTC_CRA_IRQ_EN 2
`define DTC_CRA_SEL_B 3
`define DTC_CRB_BURST_N 0
`define DTC_CRB_TEST 1
`define DTC_CRB_SINGLE 2
`define DTC_CRB_COLUMN 3
`define DTC_ST_IRQ 0
`define DTC_ST_TX_EMPTY 1
`define DTC_ST_RX_FULL 2
`define DTC_ST_DELAYED_STEER 3
`define DTC_CRA_RESET 4'h0
`define DTC_CRB_RESET 4'h0
`define DTC_RS_DATA 1'b0
`define DTC_RS_CONTROL 1'b1
`endif

// File: rtl/dtc_burst_timer.v
// Burst and pause timer for automatic tone bursts.
`timescale 1ns/1ps
module dtc_burst_timer #(
  parameter CW = 24,
  parameter [CW-1:0] BURST_CYCLES = 24'd6375000,
  parameter [CW-1:0] LONG_CYCLES = 24'd12750000
)(
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire abort,
  input wire long_sel,
  output wire burst_on,
  output reg done
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_BURST = 2'd1;
  localparam [1:0] ST_PAUSE = 2'd2;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [CW-1:0] count_reg;
  reg [CW-1:0] count_next;
  reg done_next;
  wire [CW-1:0] period;
  // The long period applies while call-progress mode is on.
  assign period = long_sel ? LONG_CYCLES : BURST_CYCLES;
  assign burst_on = (state_reg == ST_BURST);
  always @*
  begin
    state_next = state_reg;
    count_next = count_reg;
    done_next = 1'b0;
    if (abort)
    begin
      state_next = ST_IDLE;
      count_next = {CW{1'b0}};
    end
    else if (start)
    begin
      state_next = ST_BURST;
      count_next = period - {{(CW-1){1'b0}}, 1'b1};
    end
    else
    begin
      case (state_reg)
        ST_BURST:
        begin
          if (count_reg == {CW{1'b0}})
          begin
            state_next = ST_PAUSE;
            count_next = period - {{(CW-1){1'b0}}, 1'b1};
          end
          else
          begin
            count_next = count_reg - {{(CW-1){1'b0}}, 1'b1};
          end
        end
        ST_PAUSE:
        begin
          if (count_reg == {CW{1'b0}})
          begin
            state_next = ST_IDLE;
            done_next = 1'b1;
          end
          else
          begin
            count_next = count_reg - {{(CW-1){1'b0}}, 1'b1};
          end
        end
        default:
        begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      count_reg <= {CW{1'b0}};
      done <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      done <= done_next;
    end
  end
endmodule // dtc_burst_timer

// File: rtl/dtc_control_regs.v
// Control registers, status and pin logic of the tone transceiver.
`timescale 1ns/1ps
`include "dtc_consts.vh"
// Function
// - Control A bit 0 enables tone output and gates all transmit tones.
// - Control A bit 1 picks call-progress receive; zero picks tone-pair mode.
// - Call-progress mode with interrupts on puts squared tone on the pin.
// - No digit is detected or reported in call-progress mode.
// - Control A bit 2 enables the interrupt function.
// - Tone-pair mode pulls the pin low on valid digit or burst ready.
// - Control A bit 3 steers the next control write to register B.
// - Control B bit 0 low enables burst mode.
// - Each burst-mode digit gives one burst and an equal pause, 51 ms.
// - Pause end sets transmit-empty flag and raises interrupt if enabled.
// - Call-progress mode stretches burst and pause to 102 ms.
// - Without burst mode tone lasts while control A bit 0 is set.
// - Control B bit 1 enables test mode.
// - Test mode in tone-pair mode puts the delayed steer flag on the pin.
// - Control B bit 2 selects single tone; zero selects dual tone.
// - Control B bit 3 picks column tone, else row, for single tone.
// - Both control registers share one address; reads there return status.
// - Transmit-empty set at pause end, cleared by status read or non-burst.
// - Delayed steer flag sets on tone absence, clears on valid tone in tone-pair mode only.
module dtc_control_regs #(
  parameter BURST_CYCLES = `DTC_BURST_CYCLES,
  parameter LONG_CYCLES = `DTC_LONG_CYCLES
)(
  input wire CLOCK,
  input wire RESETN,
  input wire REGISTER_SELECT_LINE,
  input wire WRITE_STROBE,
  input wire READ_STROBE,
  input wire [3:0] WRITE_DATA,
  output reg [3:0] READ_DATA,
  input wire RX_TONE_VALID,
  input wire [3:0] RX_DIGIT_CODE,
  input wire RX_PROGRESS_SQUARE,
  output reg TONE_OUTPUT_ENABLE,
  output reg [3:0] TONE_DIGIT,
  output reg TONE_SINGLE,
  output reg TONE_COLUMN,
  output reg PROGRESS_MODE_SELECT,
  output reg TEST_MODE,
  output wire INTERRUPT_PROGRESS_PIN_OUT,
  output reg INTERRUPT_PROGRESS_PIN_OE
);
  localparam [`DTC_CNT_W-1:0] BURST_P = BURST_CYCLES[`DTC_CNT_W-1:0];
  localparam [`DTC_CNT_W-1:0] LONG_P = LONG_CYCLES[`DTC_CNT_W-1:0];
  reg [3:0] control_reg_a_reg;
  reg [3:0] control_reg_a_next;
  reg [3:0] control_reg_b_reg;
  reg [3:0] control_reg_b_next;
  reg second_control_select_reg;
  reg second_control_select_next;
  reg [3:0] tx_digit_reg;
  reg [3:0] tx_digit_next;
  reg [3:0] rx_digit_reg;
  reg [3:0] rx_digit_next;
  reg tx_empty_reg;
  reg tx_empty_next;
  reg rx_full_reg;
  reg rx_full_next;
  reg delayed_steer_flag_reg;
  reg delayed_steer_flag_next;
  reg tone_valid_d_reg;
  reg [3:0] read_data_next;
  reg pin_low_next;
  wire ctrl_write;
  wire data_write;
  wire status_read;
  wire rx_read;
  wire tone_en;
  wire progress_mode;
  wire irq_en;
  wire burst_mode;
  wire test_mode;
  wire tone_rise;
  wire tone_fall;
  wire burst_start;
  wire burst_abort;
  wire burst_on;
  wire burst_done;
  wire irq_flag;
  wire [3:0] status_word;
  // Decode of the parallel register bus.
  assign ctrl_write = WRITE_STROBE & (REGISTER_SELECT_LINE == `DTC_RS_CONTROL);
  assign data_write = WRITE_STROBE & (REGISTER_SELECT_LINE == `DTC_RS_DATA);
  assign status_read = READ_STROBE & (REGISTER_SELECT_LINE == `DTC_RS_CONTROL);
  assign rx_read = READ_STROBE & (REGISTER_SELECT_LINE == `DTC_RS_DATA);
  // Control field extraction.
  assign tone_en = control_reg_a_reg[`DTC_CRA_TONE_EN];
  assign progress_mode = control_reg_a_reg[`DTC_CRA_PROGRESS];
  assign irq_en = control_reg_a_reg[`DTC_CRA_IRQ_EN];
  assign burst_mode = ~control_reg_b_reg[`DTC_CRB_BURST_N];
  assign test_mode = control_reg_b_reg[`DTC_CRB_TEST];
  // Receiver event detection.
  assign tone_rise = RX_TONE_VALID & ~tone_valid_d_reg;
  assign tone_fall = ~RX_TONE_VALID & tone_valid_d_reg;
  // Burst sequencing.
  assign burst_start = data_write & burst_mode;
  assign burst_abort = ~burst_mode;
  // The interrupt summary bit follows either pending event.
  assign irq_flag = tx_empty_reg | rx_full_reg;
  assign status_word = {delayed_steer_flag_reg, rx_full_reg, tx_empty_reg, irq_flag};
  // The pin is open drain; it is only ever pulled low.
  assign INTERRUPT_PROGRESS_PIN_OUT = 1'b0;
  dtc_burst_timer #(
    .CW(`DTC_CNT_W),
    .BURST_CYCLES(BURST_P),
    .LONG_CYCLES(LONG_P)
  ) u_burst_timer (
    .clk(CLOCK),
    .rst_n(RESETN),
    .start(burst_start),
    .abort(burst_abort),
    .long_sel(progress_mode),
    .burst_on(burst_on),
    .done(burst_done)
  );
  // Control register writes through the shared address.
  always @*
  begin
    control_reg_a_next = control_reg_a_reg;
    control_reg_b_next = control_reg_b_reg;
    second_control_select_next = second_control_select_reg;
    if (ctrl_write)
    begin
      if (second_control_select_reg)
      begin
        control_reg_b_next = WRITE_DATA;
        second_control_select_next = 1'b0;
      end
      else
      begin
        control_reg_a_next = WRITE_DATA;
        second_control_select_next = WRITE_DATA[`DTC_CRA_SEL_B];
      end
    end
  end
  // Transmit and receive data registers.
  always @*
  begin
    tx_digit_next = tx_digit_reg;
    rx_digit_next = rx_digit_reg;
    if (data_write)
    begin
      tx_digit_next = WRITE_DATA;
    end
    if (tone_rise & ~progress_mode)
    begin
      rx_digit_next = RX_DIGIT_CODE;
    end
  end
  // Status flags; a setting event wins over a clearing read.
  always @*
  begin
    tx_empty_next = tx_empty_reg;
    rx_full_next = rx_full_reg;
    delayed_steer_flag_next = delayed_steer_flag_reg;
    if (status_read)
    begin
      tx_empty_next = 1'b0;
      rx_full_next = 1'b0;
    end
    if (~burst_mode)
    begin
      tx_empty_next = 1'b0;
    end
    else if (burst_done)
    begin
      tx_empty_next = 1'b1;
    end
    if (tone_rise & ~progress_mode)
    begin
      rx_full_next = 1'b1;
    end
    if (tone_rise & ~progress_mode)
    begin
      delayed_steer_flag_next = 1'b0;
    end
    else if (tone_fall)
    begin
      delayed_steer_flag_next = 1'b1;
    end
  end
  // Read data mux; the control address reads back as status.
  always @*
  begin
    read_data_next = READ_DATA;
    if (status_read)
    begin
      read_data_next = status_word;
    end
    else if (rx_read)
    begin
      read_data_next = rx_digit_reg;
    end
  end
  // Open-drain pin control.
  always @*
  begin
    pin_low_next = 1'b0;
    if (progress_mode)
    begin
      if (irq_en)
      begin
        pin_low_next = ~RX_PROGRESS_SQUARE;
      end
    end
    else if (test_mode)
    begin
      pin_low_next = ~delayed_steer_flag_next;
    end
    else if (irq_en)
    begin
      pin_low_next = rx_full_next | tx_empty_next;
    end
  end
  // State registers.
  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      control_reg_a_reg <= `DTC_CRA_RESET;
      control_reg_b_reg <= `DTC_CRB_RESET;
      second_control_select_reg <= 1'b0;
      tx_digit_reg <= 4'h0;
      rx_digit_reg <= 4'h0;
      tx_empty_reg <= 1'b0;
      rx_full_reg <= 1'b0;
      delayed_steer_flag_reg <= 1'b0;
      tone_valid_d_reg <= 1'b0;
      READ_DATA <= 4'h0;
    end
    else
    begin
      control_reg_a_reg <= control_reg_a_next;
      control_reg_b_reg <= control_reg_b_next;
      second_control_select_reg <= second_control_select_next;
      tx_digit_reg <= tx_digit_next;
      rx_digit_reg <= rx_digit_next;
      tx_empty_reg <= tx_empty_next;
      rx_full_reg <= rx_full_next;
      delayed_steer_flag_reg <= delayed_steer_flag_next;
      tone_valid_d_reg <= RX_TONE_VALID;
      READ_DATA <= read_data_next;
    end
  end
  // Registered outputs toward the tone generator and receiver.
  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      TONE_OUTPUT_ENABLE <= 1'b0;
      TONE_DIGIT <= 4'h0;
      TONE_SINGLE <= 1'b0;
      TONE_COLUMN <= 1'b0;
      PROGRESS_MODE_SELECT <= 1'b0;
      TEST_MODE <= 1'b0;
      INTERRUPT_PROGRESS_PIN_OE <= 1'b0;
    end
    else
    begin
      if (burst_mode)
      begin
        TONE_OUTPUT_ENABLE <= tone_en & burst_on;
      end
      else
      begin
        TONE_OUTPUT_ENABLE <= tone_en;
      end
      TONE_DIGIT <= tx_digit_reg;
      TONE_SINGLE <= control_reg_b_reg[`DTC_CRB_SINGLE];
      TONE_COLUMN <= control_reg_b_reg[`DTC_CRB_SINGLE] & control_reg_b_reg[`DTC_CRB_COLUMN];
      PROGRESS_MODE_SELECT <= progress_mode;
      TEST_MODE <= test_mode;
      INTERRUPT_PROGRESS_PIN_OE <= pin_low_next;
    end
  end
endmodule // dtc_control_regs

// File: testbench/dtc_chk_properties.sv
// Port assertions for the control register block.
`timescale 1ns/1ps
module dtc_chk(
  input wire CLOCK,
  input wire RESETN,
  input wire REGISTER_SELECT_LINE,
  input wire WRITE_STROBE,
  input wire READ_STROBE,
  input wire [3:0] WRITE_DATA,
  input wire [3:0] READ_DATA,
  input wire RX_PROGRESS_SQUARE,
  input wire TONE_OUTPUT_ENABLE,
  input wire TONE_SINGLE,
  input wire PROGRESS_MODE_SELECT,
  input wire TEST_MODE,
  input wire INTERRUPT_PROGRESS_PIN_OUT,
  input wire INTERRUPT_PROGRESS_PIN_OE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  reg sel_reg;
  reg tone_reg;
  reg burst_n_reg;
  wire cw = WRITE_STROBE && REGISTER_SELECT_LINE;
  wire wa = cw && !sel_reg;
  wire wb = cw && sel_reg;
  // Shadow of which control register the next write reaches.
  always @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      sel_reg <= 1'b0;
      tone_reg <= 1'b0;
      burst_n_reg <= 1'b0;
    end
    else if (cw)
    begin
      sel_reg <= wa && WRITE_DATA[3];
      if (wa)
        tone_reg <= WRITE_DATA[0];
      if (wb)
        burst_n_reg <= WRITE_DATA[0];
    end
  progress_copy_a: assert property (wa |-> ##2 PROGRESS_MODE_SELECT == $past(WRITE_DATA[1], 2))
    else $error("progress mode copy wrong");
  test_copy_a: assert property (wb |-> ##2 TEST_MODE == $past(WRITE_DATA[1], 2))
    else $error("test mode copy wrong");
  single_copy_a: assert property (wb |-> ##2 TONE_SINGLE == $past(WRITE_DATA[2], 2))
    else $error("single tone copy wrong");
  tone_gate_a: assert property (!tone_reg |=> !TONE_OUTPUT_ENABLE)
    else $error("tone on while disabled");
  steady_tone_a: assert property (tone_reg && burst_n_reg |=> TONE_OUTPUT_ENABLE)
    else $error("steady tone missing");
  status_irq_a: assert property (READ_STROBE && REGISTER_SELECT_LINE |=> READ_DATA[0] == (READ_DATA[1] || READ_DATA[2]))
    else $error("status irq bit wrong");
  progress_pin_a: assert property (PROGRESS_MODE_SELECT && $past(PROGRESS_MODE_SELECT) && $past(RX_PROGRESS_SQUARE)
    && $past(RX_PROGRESS_SQUARE, 2) |-> !INTERRUPT_PROGRESS_PIN_OE)
    else $error("progress pin wrong");
  open_drain_a: assert property (INTERRUPT_PROGRESS_PIN_OUT == 1'b0)
    else $error("pin driven high");
endmodule // dtc_chk
bind dtc_control_regs dtc_chk u_chk(.CLOCK(CLOCK), .RESETN(RESETN), .REGISTER_SELECT_LINE(REGISTER_SELECT_LINE),
  .WRITE_STROBE(WRITE_STROBE), .READ_STROBE(READ_STROBE), .WRITE_DATA(WRITE_DATA), .READ_DATA(READ_DATA),
  .RX_PROGRESS_SQUARE(RX_PROGRESS_SQUARE), .TONE_OUTPUT_ENABLE(TONE_OUTPUT_ENABLE), .TONE_SINGLE(TONE_SINGLE),
  .PROGRESS_MODE_SELECT(PROGRESS_MODE_SELECT), .TEST_MODE(TEST_MODE),
  .INTERRUPT_PROGRESS_PIN_OUT(INTERRUPT_PROGRESS_PIN_OUT), .INTERRUPT_PROGRESS_PIN_OE(INTERRUPT_PROGRESS_PIN_OE));

// File: testbench/dtc_host_model.sv
// Host processor model driving the register bus.
`timescale 1ns/1ps
module dtc_host_model(
  input wire clk,
  output reg rs = 1'b0,
  output reg wr_stb = 1'b0,
  output reg rd_stb = 1'b0,
  output reg [3:0] wdata = 4'h0,
  input wire [3:0] rdata
);
  // Data lines show the inverse of the last value once released.
  task wr(input r, input [3:0] d);
    begin
      rs <= r;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      wdata <= ~d;
      @(posedge clk);
    end
  endtask
  task rd(input r, output [3:0] d);
    begin
      rs <= r;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(posedge clk);
      d = rdata;
    end
  endtask
  task init;
    begin
      wr(1'b1, 4'h0);
      wr(1'b1, 4'h0);
      wr(1'b1, 4'h8);
      wr(1'b1, 4'h0);
    end
  endtask
endmodule // dtc_host_model

// File: testbench/test_dtc_transceiver_control_regs.sv
// Self-checking bench for the control register block.
`timescale 1ns/1ps
module test_dtc_transceiver_control_regs;
  localparam [23:0] BV = 24'h13_5D80;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg rx_valid = 1'b0;
  reg [3:0] rx_code = 4'h9;
  reg sq = 1'b1;
  reg [3:0] v;
  wire rs, wst, rds, toe, sgl, col, pms, tst, pout, poe;
  wire [3:0] wd, rd, dig;
  integer err_count = 0;
  integer total_checks = 0;
  integer i;
  integer n;
  always #4 clk = ~clk;
  dtc_host_model host (.clk(clk), .rs(rs), .wr_stb(wst), .rd_stb(rds), .wdata(wd), .rdata(rd));
  dtc_control_regs #(.BURST_CYCLES(20), .LONG_CYCLES(40)) DUT (.CLOCK(clk), .RESETN(rst_n),
    .REGISTER_SELECT_LINE(rs), .WRITE_STROBE(wst), .READ_STROBE(rds), .WRITE_DATA(wd), .READ_DATA(rd),
    .RX_TONE_VALID(rx_valid), .RX_DIGIT_CODE(rx_code), .RX_PROGRESS_SQUARE(sq), .TONE_OUTPUT_ENABLE(toe),
    .TONE_DIGIT(dig), .TONE_SINGLE(sgl), .TONE_COLUMN(col), .PROGRESS_MODE_SELECT(pms), .TEST_MODE(tst),
    .INTERRUPT_PROGRESS_PIN_OUT(pout), .INTERRUPT_PROGRESS_PIN_OE(poe));
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge clk);
  endtask
  task rc(input r, input [3:0] e);
    begin
      host.rd(r, v);
      chk(v, e);
    end
  endtask
  // Waits while the tone output equals the given level, with a bound.
  task hold(input lvl, input integer lim);
    begin
      n = 0;
      while (toe === lvl && n < lim)
      begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= lim)
      begin
        err_count = err_count + 1;
        give_verdict;
      end
    end
  endtask
  task burst(input [7:0] hi, input pe);
    begin
      host.wr(1'b0, 4'h7);
      hold(1'b0, 9);
      chk(dig, 4'h7);
      hold(1'b1, 99);
      chk(n, hi);
      @(posedge clk);
      tick(hi - 4);
      rc(1'b1, 4'h0);
      tick(6);
      chk(poe, pe);
      rc(1'b1, 4'h3);
      rc(1'b1, 4'h0);
      tick(1);
      chk(poe, 1'b0);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    host.init;
    rc(1'b1, 4'h0);
    for (i = 0; i < 6; i = i + 1)
    begin
      v = BV[i*4 +: 4];
      host.wr(1'b1, 4'h8);
      host.wr(1'b1, v);
      host.wr(1'b1, 4'h1);
      tick(2);
      chk(sgl, v[2]);
      chk(col, v[3] & v[2]);
      chk(tst, v[1]);
      chk(toe, v[0]);
      chk(poe, v[1]);
      host.wr(1'b1, 4'h0);
      tick(2);
      chk(toe, 1'b0);
    end
    host.wr(1'b1, 4'hD);
    host.wr(1'b1, 4'h0);
    burst(20, 1'b1);
    host.wr(1'b1, 4'h3);
    burst(40, 1'b0);
    host.wr(1'b1, 4'h6);
    sq <= 1'b0;
    tick(3);
    chk(poe, 1'b1);
    sq <= 1'b1;
    rx_valid <= 1'b1;
    tick(3);
    chk(poe, 1'b0);
    rx_valid <= 1'b0;
    host.rd(1'b1, v);
    chk(v[2], 1'b0);
    host.wr(1'b1, 4'h4);
    rx_valid <= 1'b1;
    tick(3);
    chk(poe, 1'b1);
    rc(1'b1, 4'h5);
    rc(1'b0, 4'h9);
    rx_valid <= 1'b0;
    tick(3);
    rc(1'b1, 4'h8);
    host.wr(1'b1, 4'h8);
    host.wr(1'b1, 4'h3);
    tick(2);
    chk(poe, 1'b0);
    rx_valid <= 1'b1;
    tick(3);
    chk(poe, 1'b1);
    give_verdict;
  end
endmodule // test_dtc_transceiver_control_regs
